/* logic/srtt_pkg.sv */
`default_nettype none
package srtt_pkg;
  localparam int BANK_W = 2;
  localparam int COL_W  = 2;
  localparam int LAT_W  = 6;
  localparam int TMR_W  = 8;
  localparam logic [7:0] MODE_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] CLR_OFS  = 8'h08;
  localparam int ST_PEND  = 0;
  localparam int ST_PRLOW = 1;
  localparam int ST_OPEN  = 4;
  localparam int ST_ERR   = 8;
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF    = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam logic [4:0] RBL_RST   = 5'h0b;
  localparam logic [4:0] WBL_RST   = 5'h09;
  localparam logic [4:0] WBL_MIN   = 5'h09;
  localparam int RTP_MIN_CK     = 4;
  localparam int RTP_MIN_PS     = 7500;
  localparam int LINK_PERIOD_PS = 64000;
  localparam int RTP_TIME_CYC   = (RTP_MIN_PS + LINK_PERIOD_PS - 1) / LINK_PERIOD_PS;
  localparam int RTP_CYC = (RTP_TIME_CYC > RTP_MIN_CK) ? RTP_TIME_CYC : RTP_MIN_CK;
  typedef enum logic [2:0] {OP_NOP, OP_ACT, OP_PRE, OP_RD, OP_WR} srtt_op_e;
  typedef struct packed {
    srtt_op_e          op;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  col;
    logic              burst_select_address_bit;
    logic              auto_precharge_address_bit;
  } srtt_cmd_s;
  typedef struct packed {
    logic       wr_pre_two;
    logic [4:0] additive_latency;
    logic [4:0] write_base_latency;
    logic [4:0] read_base_latency;
    logic [1:0] bl_mode;
  } srtt_cfg_s;
  typedef struct packed {
    logic              v;
    logic              wr;
    logic              chop;
    logic              ap;
    logic [BANK_W-1:0] bank;
    logic [COL_W-1:0]  col;
  } srtt_ent_s;
  localparam srtt_cfg_s CFG_RST = '{1'b0, 5'h00, WBL_RST, RBL_RST, BL_FIXED8};
endpackage
`default_nettype wire

/* logic/srtt_core.sv */
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
module srtt_core #(
  parameter int DQ_W    = 8,
  parameter int MAX_LAT = 40,
  parameter int RAS_CYC = 28,
  parameter int RP_CYC  = 11,
  parameter int RC_CYC  = 39
) (
  input  wire logic               core_clk_i,
  input  wire logic               rst_b_i,
  input  wire logic [7:0]         reg_addr_i,
  input  wire logic [31:0]        reg_wdata_i,
  input  wire logic               reg_wr_i,
  input  wire logic               reg_rd_i,
  output var  logic [31:0]        reg_rdata_o,
  input  wire logic               link_clk_i,
  input  wire srtt_pkg::srtt_cmd_s cmd_i,
  input  wire logic [DQ_W-1:0]    dq_i,
  output var  logic [DQ_W-1:0]    dq_o,
  output var  logic               dq_oe_o
);
  import srtt_pkg::*;
  localparam int NB = 1 << BANK_W;
  if (MAX_LAT < 2 || MAX_LAT > 62 ||
      RAS_CYC > 250 || RC_CYC > 250 || RP_CYC > 250) begin : g_bad_param
    $error("srtt_core: parameter out of range");
  end
  ////////////////////////////////////////////////////////////////////////////
  // Register side. A mode write while the previous one is still crossing is dropped,
  // which keeps the word stable while the link side samples it.
  srtt_cfg_s   cfg_r, cfg_nxt;
  logic        req_r, req_nxt, clr_r, clr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        ack_m_r, ack_s_r;
  logic        lack_r;
  logic [7:0]  st_m_r, st_s_r;
  logic        pend;
  logic [7:0]  lstat;
  assign pend = req_r ^ ack_s_r;
  always_comb begin
    cfg_nxt   = cfg_r;
    req_nxt   = req_r;
    clr_nxt   = clr_r;
    rdata_nxt = 32'h0000_0000;
    if (reg_wr_i && reg_addr_i == MODE_OFS && !pend) begin
      cfg_nxt = srtt_cfg_s'(reg_wdata_i[$bits(srtt_cfg_s)-1:0]);
      req_nxt = !req_r;
    end
    if (reg_wr_i && reg_addr_i == CLR_OFS && reg_wdata_i[0]) begin
      clr_nxt = !clr_r;
    end
    if (reg_rd_i && reg_addr_i == MODE_OFS) begin
      rdata_nxt[$bits(srtt_cfg_s)-1:0] = cfg_r;
    end
    if (reg_rd_i && reg_addr_i == STAT_OFS) begin
      rdata_nxt[ST_PEND]  = pend;
      rdata_nxt[ST_PRLOW] = cfg_r.wr_pre_two && cfg_r.write_base_latency <= WBL_MIN;
      rdata_nxt[ST_OPEN +: 4] = st_s_r[3:0];
      rdata_nxt[ST_ERR +: 4]  = st_s_r[7:4];
    end
  end
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_r   <= CFG_RST;
      req_r   <= 1'b0;
      clr_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
      ack_m_r <= 1'b0;
      ack_s_r <= 1'b0;
      st_m_r  <= 8'h00;
      st_s_r  <= 8'h00;
    end else begin
      cfg_r   <= cfg_nxt;
      req_r   <= req_nxt;
      clr_r   <= clr_nxt;
      rdata_r <= rdata_nxt;
      ack_m_r <= lack_r;
      ack_s_r <= ack_m_r;
      st_m_r  <= lstat;
      st_s_r  <= st_m_r;
    end
  end
  assign reg_rdata_o = rdata_r;
  ////////////////////////////////////////////////////////////////////////////
  // Link side: reset release, configuration and clear crossings.
  logic      lrst_m_r, lrst_b_r;
  logic      rq_m_r, rq_s_r, cl_m_r, cl_s_r, cl_seen_r;
  srtt_cfg_s lcfg_r;
  logic      lclr;
  always_ff @(posedge link_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lrst_m_r <= 1'b0;
      lrst_b_r <= 1'b0;
    end else begin
      lrst_m_r <= 1'b1;
      lrst_b_r <= lrst_m_r;
    end
  end
  assign lclr = cl_s_r ^ cl_seen_r;
  always_ff @(posedge link_clk_i or negedge lrst_b_r) begin
    if (!lrst_b_r) begin
      rq_m_r    <= 1'b0;
      rq_s_r    <= 1'b0;
      lack_r    <= 1'b0;
      cl_m_r    <= 1'b0;
      cl_s_r    <= 1'b0;
      cl_seen_r <= 1'b0;
      lcfg_r    <= CFG_RST;
    end else begin
      rq_m_r    <= req_r;
      rq_s_r    <= rq_m_r;
      lack_r    <= rq_s_r;
      cl_m_r    <= clr_r;
      cl_s_r    <= cl_m_r;
      cl_seen_r <= cl_s_r;
      lcfg_r    <= (rq_s_r != lack_r) ? cfg_r : lcfg_r;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Command decode and latency pipeline.
  logic [LAT_W-1:0] rl, wl, lat;
  logic             is_rw, cmd_chop;
  assign rl    = LAT_W'(lcfg_r.read_base_latency) + LAT_W'(lcfg_r.additive_latency);
  assign wl    = LAT_W'(lcfg_r.write_base_latency) + LAT_W'(lcfg_r.additive_latency);
  assign is_rw = cmd_i.op == OP_RD || cmd_i.op == OP_WR;
  assign lat   = (cmd_i.op == OP_WR) ? wl : rl;
  always_comb begin
    unique case (lcfg_r.bl_mode)
      BL_OTF:    cmd_chop = !cmd_i.burst_select_address_bit;
      BL_FIXED4: cmd_chop = 1'b1;
      default:   cmd_chop = 1'b0;
    endcase
  end
  srtt_ent_s pipe_r [MAX_LAT];
  srtt_ent_s pipe_nxt [MAX_LAT];
  always_comb begin
    for (int i = 0; i < MAX_LAT; i++) begin
      pipe_nxt[i] = (i == MAX_LAT - 1) ? '0 : pipe_r[i+1];
      if (is_rw && lat != '0 && int'(lat) - 1 == i) begin
        pipe_nxt[i] = '{1'b1, cmd_i.op == OP_WR, cmd_chop,
                        cmd_i.auto_precharge_address_bit, cmd_i.bank, cmd_i.col};
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Burst engine. The window is eight beats unless the next burst starts sooner; a chop moves only the first four.
  srtt_ent_s        bcur_r, bcur_nxt;
  logic             bact_r, bact_nxt, dq_oe_r, dq_oe_nxt, ap_close;
  logic [2:0]       beat_r, beat_nxt;
  logic [DQ_W-1:0]  dq_r, dq_nxt, mem [NB << (COL_W + 3)];
  logic             wr_take;
  assign wr_take  = bact_r && bcur_r.wr && !(bcur_r.chop && beat_r[2]);
  assign ap_close = bact_r && beat_r == 3'h7 && bcur_r.ap && !bcur_r.wr;
  always_comb begin
    bcur_nxt = bcur_r;
    bact_nxt = bact_r && beat_r != 3'h7;
    beat_nxt = beat_r + 3'h1;
    if (pipe_r[0].v) begin
      bcur_nxt = pipe_r[0];
      bact_nxt = 1'b1;
      beat_nxt = 3'h0;
    end
    dq_oe_nxt = bact_nxt && !bcur_nxt.wr && !(bcur_nxt.chop && beat_nxt[2]);
    dq_nxt    = dq_oe_nxt ? mem[{bcur_nxt.bank, bcur_nxt.col, beat_nxt}] : '0;
  end
  always_ff @(posedge link_clk_i or negedge lrst_b_r) begin
    if (!lrst_b_r) begin
      for (int i = 0; i < MAX_LAT; i++) begin
        pipe_r[i] <= '0;
      end
      bcur_r  <= '0;
      bact_r  <= 1'b0;
      beat_r  <= 3'h0;
      dq_oe_r <= 1'b0;
      dq_r    <= '0;
    end else begin
      pipe_r  <= pipe_nxt;
      bcur_r  <= bcur_nxt;
      bact_r  <= bact_nxt;
      beat_r  <= beat_nxt;
      dq_oe_r <= dq_oe_nxt;
      dq_r    <= dq_nxt;
    end
  end
  // Storage has no reset; data beats are only meaningful once written.
  always_ff @(posedge link_clk_i) begin
    if (wr_take) begin
      mem[{bcur_r.bank, bcur_r.col, beat_r}] <= dq_i;
    end
  end
  assign dq_o    = dq_r;
  assign dq_oe_o = dq_oe_r;
  ////////////////////////////////////////////////////////////////////////////
  // Per-bank timers. Violations are flagged, not blocked: spacing is the controller's job.
  logic [NB-1:0]    open_v;
  logic [3:0]       err_v [NB];
  logic [TMR_W-1:0] rtp_lim;
  assign rtp_lim = TMR_W'(lcfg_r.additive_latency) + TMR_W'(RTP_CYC);
  for (genvar b = 0; b < NB; b++) begin : g_bank
    logic             open_r, open_nxt, hit;
    logic [TMR_W-1:0] s_rd_r, s_rd_nxt, s_act_r, s_act_nxt, s_pre_r, s_pre_nxt;
    logic [3:0]       err_r, err_nxt, err_set;
    assign hit = cmd_i.bank == BANK_W'(b);
    always_comb begin
      s_rd_nxt  = (&s_rd_r) ? s_rd_r : s_rd_r + 1'b1;
      s_act_nxt = (&s_act_r) ? s_act_r : s_act_r + 1'b1;
      s_pre_nxt = (&s_pre_r) ? s_pre_r : s_pre_r + 1'b1;
      open_nxt  = open_r;
      err_set   = 4'h0;
      if (hit && cmd_i.op == OP_RD) begin
        s_rd_nxt = TMR_W'(1);
      end
      if (hit && cmd_i.op == OP_PRE) begin
        err_set[0] = s_rd_r < rtp_lim;
        err_set[1] = s_act_r < TMR_W'(RAS_CYC);
        s_pre_nxt  = TMR_W'(1);
        open_nxt   = 1'b0;
      end
      if (ap_close && bcur_r.bank == BANK_W'(b)) begin
        s_pre_nxt = TMR_W'(1);
        open_nxt  = 1'b0;
      end
      if (hit && cmd_i.op == OP_ACT) begin
        err_set[2] = s_pre_r < TMR_W'(RP_CYC);
        err_set[3] = s_act_r < TMR_W'(RC_CYC);
        s_act_nxt  = TMR_W'(1);
        open_nxt   = 1'b1;
      end
      err_nxt = (lclr ? 4'h0 : err_r) | err_set;
    end
    always_ff @(posedge link_clk_i or negedge lrst_b_r) begin
      if (!lrst_b_r) begin
        open_r  <= 1'b0;
        s_rd_r  <= '1;
        s_act_r <= '1;
        s_pre_r <= '1;
        err_r   <= 4'h0;
      end else begin
        open_r  <= open_nxt;
        s_rd_r  <= s_rd_nxt;
        s_act_r <= s_act_nxt;
        s_pre_r <= s_pre_nxt;
        err_r   <= err_nxt;
      end
    end
    assign open_v[b] = open_r;
    assign err_v[b]  = err_r;
  end
  always_comb begin
    lstat = 8'h00;
    for (int b = 0; b < NB; b++) begin
      lstat[b]      = open_v[b];
      lstat[7:4]    = lstat[7:4] | err_v[b];
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic [LAT_W-1:0] age_r;
  always_ff @(posedge link_clk_i or negedge lrst_b_r) begin
    if (!lrst_b_r) begin
      age_r <= '0;
    end else begin
      age_r <= is_rw ? LAT_W'(1) : age_r + LAT_W'(1);
    end
  end
  sequence s_start_rd_full;
    pipe_r[0].v && !pipe_r[0].wr && !pipe_r[0].chop;
  endsequence
  sequence s_start_rd_chop;
    pipe_r[0].v && !pipe_r[0].wr && pipe_r[0].chop;
  endsequence
  // The window is checked from the edge after the start; bursts are kept eight cycles apart.
  sequence s_full_beats;
    dq_oe_o[*8];
  endsequence
  sequence s_chop_beats;
    dq_oe_o[*4] ##1 !dq_oe_o[*4];
  endsequence
  a_rd_full_burst: assert property (@(posedge link_clk_i) disable iff (!lrst_b_r)
    s_start_rd_full |=> s_full_beats) else $error("full read short");
  a_rd_chop_idle: assert property (@(posedge link_clk_i) disable iff (!lrst_b_r)
    s_start_rd_chop |=> s_chop_beats)
    else $error("chop read not four beats");
  a_otf_select: assert property (@(posedge link_clk_i) disable iff (!lrst_b_r)
    cmd_i.op == OP_RD && lcfg_r.bl_mode == BL_OTF && rl != '0 && int'(rl) <= MAX_LAT &&
    !cmd_i.burst_select_address_bit
    |=> pipe_r[rl-LAT_W'(1)].chop) else $error("otf select ignored");
  a_fixed_chop: assert property (@(posedge link_clk_i) disable iff (!lrst_b_r)
    cmd_i.op == OP_WR && lcfg_r.bl_mode == BL_FIXED4 && wl != '0 && int'(wl) <= MAX_LAT
    |=> pipe_r[wl-LAT_W'(1)].chop)
    else $error("fixed chop ignored");
  // The age counter starts at one on the edge that takes the command, so it reads L+1 here.
  a_rd_latency: assert property (@(posedge link_clk_i) disable iff (!lrst_b_r)
    $rose(dq_oe_o) && !$past(bact_r) |-> age_r == rl + LAT_W'(1))
    else $error("read latency wrong");
  a_wr_latency: assert property (@(posedge link_clk_i) disable iff (!lrst_b_r)
    $rose(wr_take) && !$past(bact_r) |-> age_r == wl + LAT_W'(1))
    else $error("write latency wrong");
  a_ap_close: assert property (@(posedge link_clk_i) disable iff (!lrst_b_r)
    ap_close |=> !open_v[$past(bcur_r.bank)]) else $error("auto precharge kept bank open");
  a_rtp_flag: assert property (@(posedge link_clk_i) disable iff (!lrst_b_r)
    cmd_i.op == OP_RD ##2 cmd_i.op == OP_PRE && $past(cmd_i.bank, 2) == cmd_i.bank
    |=> lstat[4]) else $error("early precharge not flagged");
endmodule
`default_nettype wire

/* test/srtt_ctrl_model.sv */
`timescale 1ns/1ns
`default_nettype none
module srtt_ctrl_model #(
  parameter int RAS_CYC = 6,
  parameter int RP_CYC  = 4,
  parameter int RC_CYC  = 60
) (
  input  wire logic                link_clk_i,
  output var  srtt_pkg::srtt_cmd_s cmd_o,
  output var  logic [7:0]          dq_o
);
  import srtt_pkg::*;
  int cyc = 0;
  int al  = 0;
  int t_act [4] = '{default: -999};
  int t_pre [4] = '{default: -999};
  int t_rd  [4] = '{default: -999};
  initial cmd_o = '{OP_NOP, 2'h0, 2'h0, 1'b0, 1'b0};
  initial dq_o = 8'h00;
  always @(posedge link_clk_i) cyc <= cyc + 1;
  //////////////////////////////////////////////////////////////////////////////
  // Spacing is kept only when lg is set, so that a scenario can provoke the flags.
  task automatic send(input srtt_op_e op, input logic [1:0] b, c, input logic bs, ap, lg,
                      input int lat, n);
    @(posedge link_clk_i);
    while (lg && op == OP_PRE && (cyc < t_rd[b] + al + RTP_CYC || cyc < t_act[b] + RAS_CYC))
      @(posedge link_clk_i);
    while (lg && op == OP_ACT && (cyc < t_pre[b] + RP_CYC || cyc < t_act[b] + RC_CYC))
      @(posedge link_clk_i);
    cmd_o <= '{op, b, c, bs, ap};
    if (op == OP_ACT) t_act[b] = cyc;
    if (op == OP_PRE) t_pre[b] = cyc;
    if (op == OP_RD) t_rd[b] = cyc;
    @(posedge link_clk_i);
    cmd_o <= '{OP_NOP, 2'h0, 2'h0, 1'b0, 1'b0};
    if (op == OP_WR) begin
      repeat (lat) @(posedge link_clk_i);
      for (int j = 0; j < n; j++) begin
        dq_o <= {b, c, 4'(j)};
        @(posedge link_clk_i);
      end
      // The bus is released with the inverse value so stale data never match.
      dq_o <= ~dq_o;
    end
  endtask
endmodule
`default_nettype wire

/* test/srtt_core_bench.sv */
`timescale 1ns/1ns
`default_nettype none
module srtt_core_bench;
  import srtt_pkg::*;
  logic        core_clk;
  logic        link_clk;
  logic        rst_b;
  logic        reg_wr;
  logic        reg_rd;
  logic        dq_oe;
  logic [7:0]  reg_addr;
  logic [7:0]  dq_in;
  logic [7:0]  dq_out;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic [31:0] d;
  srtt_cmd_s   cmd;
  int          errors = 0;
  int          checks = 0;
  srtt_core #(.RAS_CYC(6), .RP_CYC(4), .RC_CYC(60)) i_srtt_core (
    .core_clk_i(core_clk), .rst_b_i(rst_b), .reg_addr_i(reg_addr),
    .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(reg_rdata), .link_clk_i(link_clk), .cmd_i(cmd),
    .dq_i(dq_in), .dq_o(dq_out), .dq_oe_o(dq_oe));
  srtt_ctrl_model i_srtt_ctrl_model (
    .link_clk_i(link_clk), .cmd_o(cmd), .dq_o(dq_in));
  //////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask
  // Status lags the link side by a few edges, so it is polled under a bound.
  task automatic wstat(input logic [31:0] m, input logic [31:0] x);
    logic [31:0] v;
    for (int i = 0; i < 40; i++) begin
      rreg(STAT_OFS, v);
      if ((v & m) === x) break;
    end
    chk("status", v & m, x);
    if ((v & m) !== x) test_done();
  endtask
  function automatic logic [31:0] mw(input logic [1:0] bl, input int rb, wb, al,
                                     input logic pre);
    return {14'h0, pre, al[4:0], wb[4:0], rb[4:0], bl};
  endfunction
  task automatic setmode(input logic [31:0] v, input int a);
    wreg(MODE_OFS, v);
    i_srtt_ctrl_model.al = a;
    repeat (8) @(posedge link_clk);
    wstat(32'h0000_0001, 32'h0000_0000);
  endtask
  task automatic send(input srtt_op_e op, input logic [1:0] b, c, input logic bs, ap, lg,
                      input int lat, n);
    i_srtt_ctrl_model.send(op, b, c, bs, ap, lg, lat, n);
  endtask
  task automatic rdchk(input logic [1:0] b, c, input logic bs, ap, input int lat, n);
    send(OP_RD, b, c, bs, ap, 1'b1, lat, n);
    repeat (lat) @(posedge link_clk);
    for (int j = 0; j < 9; j++) begin
      @(negedge link_clk);
      chk("dq_oe", {31'h0, dq_oe}, {31'h0, j < n});
      if (j < n) chk("dq", {24'h0, dq_out}, {24'h0, b, c, 4'(j)});
    end
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #2;
    forever #32 link_clk = ~link_clk;
  end
  initial begin
    #900_000;
    errors++;
    test_done();
  end
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (4) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (3) @(posedge link_clk);
    rreg(MODE_OFS, d);
    chk("mode", d, 32'h0000_04ac);
    rreg(STAT_OFS, d);
    chk("status", d, 32'h0000_0000);
    rreg(8'h0c, d);
    chk("unmapped", d, 32'h0000_0000);
    send(OP_ACT, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 0, 0);
    wstat(32'h0000_00f0, 32'h0000_0010);
    send(OP_WR, 2'h0, 2'h0, 1'b0, 1'b0, 1'b1, 9, 8);
    rdchk(2'h0, 2'h0, 1'b0, 1'b0, 11, 8);
    setmode(mw(2'h1, 11, 9, 2, 1'b0), 2);
    send(OP_WR, 2'h0, 2'h1, 1'b0, 1'b0, 1'b1, 11, 4);
    rdchk(2'h0, 2'h1, 1'b0, 1'b0, 13, 4);
    rdchk(2'h0, 2'h0, 1'b1, 1'b0, 13, 8);
    setmode(mw(2'h2, 11, 9, 0, 1'b1), 0);
    wstat(32'h0000_0002, 32'h0000_0002);
    send(OP_WR, 2'h0, 2'h2, 1'b1, 1'b0, 1'b1, 9, 4);
    rdchk(2'h0, 2'h2, 1'b1, 1'b0, 11, 4);
    rdchk(2'h0, 2'h0, 1'b1, 1'b0, 11, 4);
    wstat(32'h0000_00f0, 32'h0000_0010);
    rdchk(2'h0, 2'h0, 1'b1, 1'b1, 11, 4);
    wstat(32'h0000_00f0, 32'h0000_0000);
    setmode(mw(2'h0, 11, 10, 0, 1'b1), 0);
    wstat(32'h0000_0002, 32'h0000_0000);
    send(OP_ACT, 2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 0, 0);
    send(OP_PRE, 2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 0, 0);
    wstat(32'h0000_0f00, 32'h0000_0200);
    wreg(CLR_OFS, 32'h0000_0001);
    wstat(32'h0000_0f00, 32'h0000_0000);
    send(OP_ACT, 2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 0, 0);
    repeat (8) @(posedge link_clk);
    send(OP_RD, 2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 11, 8);
    send(OP_PRE, 2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 0, 0);
    wstat(32'h0000_0f00, 32'h0000_0100);
    wreg(CLR_OFS, 32'h0000_0001);
    wstat(32'h0000_0f00, 32'h0000_0000);
    send(OP_PRE, 2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 0, 0);
    send(OP_ACT, 2'h2, 2'h0, 1'b0, 1'b0, 1'b0, 0, 0);
    wstat(32'h0000_0f00, 32'h0000_0c00);
    wreg(CLR_OFS, 32'h0000_0001);
    wstat(32'h0000_0f00, 32'h0000_0000);
    send(OP_PRE, 2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 0, 0);
    send(OP_ACT, 2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 0, 0);
    send(OP_RD, 2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 11, 8);
    send(OP_PRE, 2'h2, 2'h0, 1'b0, 1'b0, 1'b1, 0, 0);
    repeat (8) @(posedge link_clk);
    wstat(32'h0000_0f00, 32'h0000_0000);
    test_done();
  end
endmodule
`default_nettype wire
